// [logic/hfo_consts.vh]
// constants of the heading filter and output scheduler
// assumes a 100 MHz pclk and an APB register window of 32-bit words
`ifndef HFO_CONSTS_VH
`define HFO_CONSTS_VH
// register byte addresses
`define HFO_ADDR_CFG 8'h00
`define HFO_ADDR_DECL 8'h04
`define HFO_ADDR_SDLY 8'h08
`define HFO_ADDR_CMD 8'h0C
`define HFO_ADDR_STAT 8'h10
`define HFO_ADDR_WCFG 8'h14
`define HFO_ADDR_SCFG 8'h18
// settings word fields
`define HFO_F_BAUD 2:0
`define HFO_F_MOUNT 6:3
`define HFO_B_MILS 7
`define HFO_B_TRUE 8
`define HFO_F_TAPS 11:9
`define HFO_B_GYRO 12
`define HFO_B_FLUSH 13
`define HFO_B_CONT 14
// factory settings: 38400 baud, standard mount, degrees, magnetic,
// 32 taps, compass mode, no flush, polled
`define HFO_CFG_RST 15'h0804
`define HFO_DECL_RST 16'h0000
`define HFO_SDLY_RST 16'h0000
`define HFO_BAUD_CODE_RST 3'h4
// command word bits
`define HFO_C_APPLY 0
`define HFO_C_SAVE 1
`define HFO_C_DEFAULT 2
`define HFO_C_POWER 3
`define HFO_C_POLL 4
// angles and units
`define HFO_BAUD_DEFAULT 18'h09600 // 38400 baud
`define HFO_TAPS_MAX 32
`define HFO_TAPS_CODE_MAX 3'h4
`define HFO_MOUNTS 16
`define HFO_CENTI_CIRCLE 19'sh08CA0 // 36000 centidegrees
`define HFO_MILS_CIRCLE 6400
// sample delay unit is one millisecond
`define HFO_CLK_NS 10
`define HFO_DLY_UNIT_NS 1000000
`endif

// [logic/hfo_fifo.v]
// first-word-fall-through fifo with registered read data
// assumes DEPTH is a power of two and AW = log2(DEPTH)
`timescale 1ns/1ns
module hfo_fifo #(
  parameter W = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire wr_valid,
  output wire wr_ready,
  input wire [W-1:0] wr_data,
  output reg rd_valid,
  input wire rd_ready,
  output reg [W-1:0] rd_data,
  output reg [AW:0] level
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  wire do_rd = rd_valid && rd_ready;
  // full fifo still takes a word while one leaves
  assign wr_ready = (level != DEPTH[AW:0]) || do_rd;
  wire do_wr = wr_valid && wr_ready;
  wire [AW-1:0] rp_n = do_rd ? rp + 1'b1 : rp;
  wire [AW:0] next_level = level + {{AW{1'b0}}, do_wr}
    - {{AW{1'b0}}, do_rd};

  // storage, no reset needed
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr_data;
    end
  end

  // pointers, level and prefetched head word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      rd_valid <= 1'b0;
      rd_data <= {W{1'b0}};
    end else if (clr) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      rd_valid <= 1'b0;
    end else begin
      if (do_wr) begin
        wp <= wp + 1'b1;
      end
      rp <= rp_n;
      level <= next_level;
      rd_valid <= (next_level != {(AW+1){1'b0}});
      rd_data <= (do_wr && wp == rp_n) ? wr_data : mem[rp_n]; // bypass
    end
  end
endmodule

// [logic/hfo_top.v]
// heading, pitch and roll smoothing, unit conversion and output pacing
// assumes samples and poll requests come from logic on pclk
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "hfo_consts.vh"
module hfo_top #(
  parameter DLY_UNIT_CYC = `HFO_DLY_UNIT_NS / `HFO_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire samp_valid,
  input wire [16:0] samp_heading,
  input wire [16:0] samp_pitch,
  input wire [16:0] samp_roll,
  input wire poll_req,
  output wire set_valid,
  input wire set_ready,
  output wire [53:0] set_data,
  output reg [17:0] baud_rate,
  output reg [3:0] mount_sel
);
  localparam S_IDLE = 2'h0;
  localparam S_SENT = 2'h1;
  localparam S_DELAY = 2'h2;

  // taps code to log2 of window length, zero for code 0 and the unused codes
  function [2:0] taps_lg;
    input [2:0] code;
    begin
      case (code)
        3'h1: taps_lg = 3'h2;
        3'h2: taps_lg = 3'h3;
        3'h3: taps_lg = 3'h4;
        3'h4: taps_lg = 3'h5;
        default: taps_lg = 3'h0;
      endcase
    end
  endfunction

  // baud code to rate
  function [17:0] baud_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: baud_of = 18'd2400;
        3'h1: baud_of = 18'd4800;
        3'h2: baud_of = 18'd9600;
        3'h3: baud_of = 18'd19200;
        3'h5: baud_of = 18'd57600;
        3'h6: baud_of = 18'd115200;
        3'h7: baud_of = 18'd230400;
        default: baud_of = `HFO_BAUD_DEFAULT;
      endcase
    end
  endfunction

  // centidegrees to output units (centidegrees or tenth-mils)
  function [17:0] to_units;
    input signed [18:0] x;
    input mils;
    reg signed [35:0] p; // full circle times 64000 needs more than 32 bits
    begin
      p = x * (`HFO_MILS_CIRCLE * 10) / `HFO_CENTI_CIRCLE;
      to_units = mils ? p[17:0] : x[17:0];
    end
  endfunction

  reg [14:0] pend_cfg;
  reg [15:0] pend_decl;
  reg [15:0] pend_sdly;
  reg [14:0] work_cfg;
  reg [15:0] work_decl;
  reg [15:0] work_sdly;
  reg [14:0] save_cfg;
  reg [15:0] save_decl;
  reg [15:0] save_sdly;
  reg [2:0] act_baud;
  reg [5:0] fill;
  reg signed [21:0] sum_h;
  reg signed [21:0] sum_p;
  reg signed [21:0] sum_r;
  reg [50:0] raw;
  reg raw_valid;
  reg poll_pend;
  reg [1:0] state;
  reg [15:0] cnt_ms;
  reg [31:0] cnt_unit;

  wire acc = psel && penable && !pready;
  wire wr_en = acc && pwrite;
  wire cmd_wr = wr_en && paddr == `HFO_ADDR_CMD;
  wire c_apply = cmd_wr && pwdata[`HFO_C_APPLY];
  wire c_save = cmd_wr && pwdata[`HFO_C_SAVE];
  wire c_default = cmd_wr && pwdata[`HFO_C_DEFAULT];
  wire c_power = cmd_wr && pwdata[`HFO_C_POWER];
  wire c_poll = cmd_wr && pwdata[`HFO_C_POLL];
  wire cont = work_cfg[`HFO_B_CONT];
  wire [2:0] lg = taps_lg(work_cfg[`HFO_F_TAPS]);
  wire fir_on = !work_cfg[`HFO_B_GYRO] && lg != 3'h0;
  wire [5:0] ntaps = 6'h01 << lg;
  wire full_win = fill == ntaps;

  // apply paths
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_cfg <= `HFO_CFG_RST;
      pend_decl <= `HFO_DECL_RST;
      pend_sdly <= `HFO_SDLY_RST;
      work_cfg <= `HFO_CFG_RST;
      work_decl <= `HFO_DECL_RST;
      work_sdly <= `HFO_SDLY_RST;
      save_cfg <= `HFO_CFG_RST;
      save_decl <= `HFO_DECL_RST;
      save_sdly <= `HFO_SDLY_RST;
      act_baud <= `HFO_BAUD_CODE_RST;
      baud_rate <= `HFO_BAUD_DEFAULT;
      mount_sel <= 4'h0;
    end else begin
      if (wr_en && paddr == `HFO_ADDR_CFG) begin
        pend_cfg[14:12] <= pwdata[14:12];
        pend_cfg[8:0] <= pwdata[8:0];
        if (pwdata[`HFO_F_TAPS] <= `HFO_TAPS_CODE_MAX) begin
          pend_cfg[`HFO_F_TAPS] <= pwdata[`HFO_F_TAPS];
        end
      end
      if (wr_en && paddr == `HFO_ADDR_DECL) begin
        pend_decl <= pwdata[15:0];
      end
      if (wr_en && paddr == `HFO_ADDR_SDLY) begin
        pend_sdly <= pwdata[15:0];
      end
      if (c_default) begin
        pend_cfg <= `HFO_CFG_RST; // staged only
        pend_decl <= `HFO_DECL_RST;
        pend_sdly <= `HFO_SDLY_RST;
      end
      if (c_apply || c_save) begin
        work_cfg <= pend_cfg;
        work_decl <= pend_decl;
        work_sdly <= pend_sdly;
        mount_sel <= pend_cfg[`HFO_F_MOUNT];
      end
      if (c_save) begin
        save_cfg <= pend_cfg;
        save_decl <= pend_decl;
        save_sdly <= pend_sdly;
      end
      if (c_power) begin
        work_cfg <= save_cfg;
        work_decl <= save_decl;
        work_sdly <= save_sdly;
        pend_cfg <= save_cfg;
        pend_decl <= save_decl;
        pend_sdly <= save_sdly;
        mount_sel <= save_cfg[`HFO_F_MOUNT];
        act_baud <= save_cfg[`HFO_F_BAUD];
        baud_rate <= baud_of(save_cfg[`HFO_F_BAUD]);
      end
    end
  end

  // window storage of packed heading, pitch and roll samples
  wire [50:0] new_s = {samp_heading, samp_pitch, samp_roll};
  wire [50:0] old_s;
  wire ofifo_ready;
  wire [2:0] olevel;
  wire cur_valid = fir_on ? full_win : raw_valid;
  wire push = state == S_IDLE && cur_valid && ofifo_ready
    && (cont || poll_pend);
  // clear on flush after each set, and on any settings change
  wire flush = (push && work_cfg[`HFO_B_FLUSH] && fir_on)
    || c_apply || c_save || c_power;
  wire take = samp_valid && fir_on && !flush;
  wire pop_old = take && full_win;

  hfo_fifo #(.W(51), .DEPTH(`HFO_TAPS_MAX), .AW(5)) u_win (
    .clk(pclk),
    .rst_n(presetn),
    .clr(flush),
    .wr_valid(take),
    .wr_ready(),
    .wr_data(new_s),
    .rd_valid(),
    .rd_ready(pop_old),
    .rd_data(old_s),
    .level()
  );

  // running sums of the window, raw pass-through latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill <= 6'h00;
      sum_h <= 22'sd0;
      sum_p <= 22'sd0;
      sum_r <= 22'sd0;
      raw <= 51'h0;
      raw_valid <= 1'b0;
    end else begin
      if (flush) begin
        fill <= 6'h00;
        sum_h <= 22'sd0;
        sum_p <= 22'sd0;
        sum_r <= 22'sd0;
      end else if (take) begin
        sum_h <= sum_h + {5'h00, new_s[50:34]}
          - (pop_old ? {5'h00, old_s[50:34]} : 22'sd0);
        sum_p <= sum_p + {{5{new_s[33]}}, new_s[33:17]}
          - (pop_old ? {{5{old_s[33]}}, old_s[33:17]} : 22'sd0);
        sum_r <= sum_r + {{5{new_s[16]}}, new_s[16:0]}
          - (pop_old ? {{5{old_s[16]}}, old_s[16:0]} : 22'sd0);
        if (!full_win) begin
          fill <= fill + 6'h01;
        end
      end
      if (samp_valid) begin
        raw <= new_s;
        raw_valid <= 1'b1;
      end
    end
  end

  // mean or raw, north reference, units
  wire [21:0] mh = sum_h >>> lg;
  wire [21:0] mp = sum_p >>> lg;
  wire [21:0] mr = sum_r >>> lg;
  wire [16:0] fh = fir_on ? mh[16:0] : raw[50:34];
  wire [16:0] fp = fir_on ? mp[16:0] : raw[33:17];
  wire [16:0] fr = fir_on ? mr[16:0] : raw[16:0];
  wire signed [18:0] hd = {2'b00, fh} + (work_cfg[`HFO_B_TRUE] ?
    {{3{work_decl[15]}}, work_decl} : 19'sd0);
  wire signed [18:0] hw = hd < 0 ? hd + `HFO_CENTI_CIRCLE :
    (hd >= `HFO_CENTI_CIRCLE ? hd - `HFO_CENTI_CIRCLE : hd);
  wire mils = work_cfg[`HFO_B_MILS];
  wire [53:0] set_word = {to_units(hw, mils),
    to_units({{2{fp[16]}}, fp}, mils), to_units({{2{fr[16]}}, fr}, mils)};

  hfo_fifo #(.W(54), .DEPTH(4), .AW(2)) u_out (
    .clk(pclk),
    .rst_n(presetn),
    .clr(1'b0),
    .wr_valid(push),
    .wr_ready(ofifo_ready),
    .wr_data(set_word),
    .rd_valid(set_valid),
    .rd_ready(set_ready),
    .rd_data(set_data),
    .level(olevel)
  );

  // output pacing: polled requests or continuous with sample delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_pend <= 1'b0;
      state <= S_IDLE;
      cnt_ms <= 16'h0000;
      cnt_unit <= 32'h0;
    end else begin
      poll_pend <= poll_req || c_poll // set wins over clear
        || (poll_pend && !push && !cont);
      case (state)
        S_IDLE: begin
          if (push && cont) begin
            state <= S_SENT;
          end
        end
        S_SENT: begin
          if (!cont) begin
            state <= S_IDLE;
          end else if (olevel == 3'h0) begin
            cnt_ms <= 16'h0000;
            cnt_unit <= 32'h0;
            state <= (work_sdly == 16'h0000) ? S_IDLE : S_DELAY;
          end
        end
        S_DELAY: begin
          if (!cont) begin
            state <= S_IDLE;
          end else if (cnt_unit == DLY_UNIT_CYC - 1) begin
            cnt_unit <= 32'h0;
            cnt_ms <= cnt_ms + 16'h0001;
            if (cnt_ms + 16'h0001 >= work_sdly) begin
              state <= S_IDLE;
            end
          end else begin
            cnt_unit <= cnt_unit + 32'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // apb slave, one wait state per access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (acc) begin
        case (paddr)
          `HFO_ADDR_CFG: prdata <= {17'h0, pend_cfg};
          `HFO_ADDR_DECL: prdata <= {16'h0, pend_decl};
          `HFO_ADDR_SDLY: prdata <= {16'h0, pend_sdly};
          `HFO_ADDR_CMD: prdata <= 32'h0;
          `HFO_ADDR_STAT: prdata <= {16'h0, act_baud, state, olevel,
            poll_pend, cur_valid, fill};
          `HFO_ADDR_WCFG: prdata <= {17'h0, work_cfg};
          `HFO_ADDR_SCFG: prdata <= {17'h0, save_cfg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// [tb/hfo_chk_sva.sv]
// assertions on the apb and output ports of hfo_top
// assumes one pclk domain, bound to every hfo_top
`timescale 1ns/1ns
`include "hfo_consts.vh"
module hfo_chk (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire set_valid,
  input wire set_ready,
  input wire [53:0] set_data,
  input wire [17:0] baud_rate,
  input wire [3:0] mount_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // command writes as taken at the access edge
  wire acc = psel && penable && !pready;
  wire cmdw = acc && pwrite && paddr == `HFO_ADDR_CMD;
  wire pwr = cmdw && pwdata[3];
  wire wrk = cmdw && (pwdata[0] || pwdata[1] || pwdata[3]);
  apb_wait_a: assert property (acc |=> pready)
    else $error("no ready after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  set_hold_a: assert property (set_valid && !set_ready |=>
    set_valid && $stable(set_data))
    else $error("set dropped before taken");
  baud_cmd_a: assert property (!$stable(baud_rate) |->
    $past(pwr) || $past(pwr, 2))
    else $error("baud changed without power cycle");
  mount_cmd_a: assert property (!$stable(mount_sel) |->
    $past(wrk) || $past(wrk, 2))
    else $error("mount changed without command");
endmodule
bind hfo_top hfo_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .set_valid, .set_ready,
  .set_data, .baud_rate, .mount_sel);

// [tb/hfo_host.sv]
// host model: takes output sets and issues poll requests
// assumes tb drives stall and kick just after pclk rising edges
`timescale 1ns/1ns
module hfo_host (
  input wire pclk,
  input wire presetn,
  input wire set_valid,
  input wire [53:0] set_data,
  input wire stall,
  input wire kick,
  output reg set_ready,
  output reg poll_req,
  output reg [15:0] n_got,
  output reg [53:0] last,
  output reg [15:0] gap
);
  reg [15:0] cnt;
  // one request per kick, issued on the clock edge after the kick
  // takes sets unless stalled, times the gap between takes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_ready <= 1'b0;
      poll_req <= 1'b0;
      n_got <= 16'h0;
      last <= 54'h0;
      gap <= 16'h0;
      cnt <= 16'h0;
    end else begin
      poll_req <= kick;
      set_ready <= !stall;
      cnt <= cnt + 16'h1;
      if (set_valid && set_ready) begin
        n_got <= n_got + 16'h1;
        last <= set_data;
        gap <= cnt;
        cnt <= 16'h0;
      end
    end
  end
endmodule

// [tb/tb.sv]
// self-checking bench of hfo_top with a host model on the set port
// assumes hfo_top, hfo_host and the checker are compiled before it
`timescale 1ns/1ns
`include "hfo_consts.vh"
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 8'h0;
  reg [31:0] pwdata = 32'h0, rd;
  reg samp_valid = 0, stall = 0, kick = 0, er;
  reg [16:0] samp_heading = 17'h0, samp_pitch = 17'h0, samp_roll = 17'h0;
  wire [31:0] prdata;
  wire pready, pslverr, set_valid, set_ready, poll_req;
  wire [53:0] set_data, last;
  wire [17:0] baud_rate;
  wire [3:0] mount_sel;
  wire [15:0] n_got, gap;
  integer num_errors = 0, cmp_count = 0, cyc = 0;
  hfo_top #(.DLY_UNIT_CYC(4)) DUT (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .samp_valid,
    .samp_heading, .samp_pitch, .samp_roll, .poll_req, .set_valid,
    .set_ready, .set_data, .baud_rate, .mount_sel);
  hfo_host host (.pclk, .presetn, .set_valid, .set_data, .stall, .kick,
    .set_ready, .poll_req, .n_got, .last, .gap);
  initial forever #5 pclk = ~pclk;
  // cuts a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string n, input [53:0] e, input [53:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  function [53:0] pk(input int h, input int p, input int r);
    pk = {h[17:0], p[17:0], r[17:0]};
  endfunction
  // one apb transfer, held until pready is sampled high
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task samp(input int h, input int p, input int r);
    begin
      @(posedge pclk);
      samp_valid <= 1;
      samp_heading <= h[16:0];
      samp_pitch <= p[16:0];
      samp_roll <= r[16:0];
      @(posedge pclk);
      samp_valid <= 0;
    end
  endtask
  task poll;
    begin
      @(posedge pclk);
      kick <= 1;
      @(posedge pclk);
      kick <= 0;
    end
  endtask
  task waitn(input int n);
    int k;
    begin
      k = 0;
      while (n_got < n && k < 400) begin
        @(posedge pclk);
        k++;
      end
    end
  endtask
  task getset(input int p, input [53:0] e);
    int n0;
    begin
      n0 = n_got;
      if (p == 1)
        poll;
      else if (p == 2)
        apb(1, `HFO_ADDR_CMD, 32'h10);
      waitn(n0 + 1);
      chk("set", e, last);
    end
  endtask
  task t_reset;
    begin
      apb(0, `HFO_ADDR_CFG, 0);
      chk("cfg", 32'h0804, rd);
      chk("baud", 18'h09600, baud_rate);
      chk("mount", 4'h0, mount_sel);
      apb(0, 8'h1C, 0);
      chk("err", 1'b1, er);
      chk("rdata", 32'h0, rd);
      apb(1, `HFO_ADDR_CFG, 32'h0A04);
      apb(0, `HFO_ADDR_CFG, 0);
      chk("taps", 32'h0804, rd);
    end
  endtask
  // save new baud and mount, then default and power cycle
  task t_cfg;
    begin
      apb(1, `HFO_ADDR_CFG, 32'h082E);
      apb(1, `HFO_ADDR_CMD, 32'h2);
      chk("baud", 18'h09600, baud_rate);
      chk("mount", 4'h5, mount_sel);
      apb(1, `HFO_ADDR_CFG, 32'h0804);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      chk("mount", 4'h0, mount_sel);
      apb(1, `HFO_ADDR_CMD, 32'h4);
      apb(1, `HFO_ADDR_CMD, 32'h8);
      chk("baud", 18'h1C200, baud_rate);
      apb(0, `HFO_ADDR_WCFG, 0);
      chk("wcfg", 32'h082E, rd);
    end
  endtask
  task t_taps;
    int c, n, k, s, a, b, q;
    begin
      for (c = 0; c < 5; c++) begin
        n = c ? 2 << c : 0;
        s = c ? c + 1 : 0;
        apb(1, `HFO_ADDR_CFG, 32'h0004 | c << 9);
        apb(1, `HFO_ADDR_CMD, 32'h1);
        a = 0;
        b = 0;
        q = 0;
        for (k = 0; k < 2 * n + 2; k++) begin
          samp(100 * k, -k, 3 * k);
          if (k > n + 1) begin
            a += 100 * k;
            b -= k;
            q += 3 * k;
          end
        end
        if (n)
          getset(1, pk(a >>> s, b >>> s, q >>> s));
        else
          getset(1, pk(100, -1, 3));
      end
    end
  endtask
  task t_modes;
    begin
      apb(1, `HFO_ADDR_CFG, 32'h1804);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      samp(1234, -50, 60);
      getset(1, pk(1234, -50, 60));
      apb(1, `HFO_ADDR_CFG, 32'h0084);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      samp(9000, -4500, 0);
      getset(1, pk(16000, -8000, 0));
      apb(1, `HFO_ADDR_CFG, 32'h0104);
      apb(1, `HFO_ADDR_DECL, 32'h01F4);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      samp(35800, 0, 0);
      getset(2, pk(300, 0, 0));
    end
  endtask
  // second round relies on the flush after each pushed set
  task t_flush;
    int j, k, n0;
    begin
      apb(1, `HFO_ADDR_CFG, 32'h2204);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      for (j = 0; j < 2; j++) begin
        for (k = 0; k < 4; k++) begin
          if (k == 3) begin
            n0 = n_got;
            poll;
            repeat (20) @(posedge pclk);
            chk("held", n0, n_got);
          end
          samp(400 * k, -k, 0);
        end
        getset(0, pk(600, -2, 0));
      end
    end
  endtask
  // fill the output fifo with the host stalled, then drain it
  task t_fifo;
    int k, n0;
    begin
      apb(1, `HFO_ADDR_CFG, 32'h0004);
      apb(1, `HFO_ADDR_CMD, 32'h1);
      samp(7, 7, 7);
      stall <= 1;
      for (k = 0; k < 6; k++) begin
        poll;
        repeat (3) @(posedge pclk);
      end
      apb(0, `HFO_ADDR_STAT, 0);
      chk("level", 3'h4, rd[10:8]);
      chk("pending", 1'b1, rd[7]);
      n0 = n_got;
      stall <= 0;
      waitn(n0 + 5);
      repeat (20) @(posedge pclk);
      chk("count", n0 + 5, n_got);
    end
  endtask
  task t_cont;
    int d, n0;
    begin
      for (d = 0; d < 4; d += 2) begin
        apb(1, `HFO_ADDR_SDLY, d);
        apb(1, `HFO_ADDR_CFG, 32'h4004);
        apb(1, `HFO_ADDR_CMD, 32'h1);
        n0 = n_got;
        samp(5, 5, 5);
        waitn(n0 + 3);
        chk("sets", n0 + 3, n_got);
        chk("gap", 1'b1, gap >= 4 * d + 1 && gap <= 4 * d + 8);
        apb(1, `HFO_ADDR_CFG, 32'h0004);
        apb(1, `HFO_ADDR_CMD, 32'h1);
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_cfg;
    t_taps;
    t_modes;
    t_flush;
    t_fifo;
    t_cont;
    print_verdict;
  end
endmodule
